/* shared/fx_decoder_defines.vh */
// constants for the videowall effects command decoder
// What this block does
// - code 45 takes a speed byte; larger is slower, zero stops strobing
// - strobe freezes the store by field or frame; other effects stay usable
// - code 46: 0 interlaced, 1 progressive text mode
// - code 48 stores a signed line offset for the given split factor
// - code 47 sends 25 select flags; only selected monitors obey globals
// - after reset every monitor is selected
// - commands naming one monitor act on it regardless of the mask
// - code 51 draws a pattern: field 0 or 1, split 0 to 5
// - pattern is two diagonals and a numbered circle; no font
// - code 52 wipes: directions 0 to 5, targets A, B, graphics colour
// - wipe speed 1 to 255 faster when larger; zero is instant
// - second input is timebase-corrected to the main input
// - code 55: 0 stores every field, 1 alternate fields only
// - code 56 picks the quarter-size quadrant 0 to 3
// - code 57 shows or hides the second source at its set size
// - code 58: 0 full, 1 quarter screen dropping alternate pixels
// - code 59 holds the second source independently of the main one
// - code 101 zooms about X,Y sent low byte first in 380x300
// - zoom supports only the 50 percent factor
`ifndef FX_DECODER_DEFINES_VH
`define FX_DECODER_DEFINES_VH
`define FN_STROBE 8'h2D
`define FN_SCAN 8'h2E
`define FN_SELECT 8'h2F
`define FN_OFFSET 8'h30
`define FN_PATTERN 8'h33
`define FN_WIPE 8'h34
`define FN_SKIP 8'h37
`define FN_QUAD 8'h38
`define FN_SHOW 8'h39
`define FN_SCALE 8'h3A
`define FN_HOLD 8'h3B
`define FN_ZOOM 8'h65
`define NUM_MON 8'h19
`define NUM_SPLIT 8'h08
`define ZOOM_X_MAX 16'h017B
`define ZOOM_Y_MAX 16'h012B
`define ZOOM_HALF 8'h32
`define MASK_ALL 25'h1FFFFFF
`endif

/* verilog/strobe_timer.v */
// field-counting strobe capture timer
`timescale 1ns/100ps
module strobe_timer (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // field timing and setting
  input wire field_start,
  input wire [7:0] speed,
  // capture request, one cycle
  output reg capture
);
  reg [7:0] count;
  // count fields; a capture every speed fields, never when speed is zero
  always @(posedge clk) begin
    if (sys_rst) begin
      count <= 8'h00;
      capture <= 1'b0;
    end else begin
      capture <= 1'b0;
      if (speed == 8'h00) begin
        count <= 8'h00;
      end else if (field_start) begin
        if (count + 8'h01 >= speed) begin
          count <= 8'h00;
          capture <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule // strobe_timer

/* verilog/fx_command_decoder.v */
// effects and second-source command decoder
`timescale 1ns/100ps
`include "fx_decoder_defines.vh"
module fx_command_decoder (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // incoming command bytes
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire frame_start,
  // video timing
  input wire field_start,
  input wire field_odd,
  // strobe
  output reg [7:0] strobe_speed,
  output reg strobe_freeze,
  output reg strobe_capture,
  // scan
  output reg progressive_scan_cmd,
  output reg [63:0] field_line_offset_cmd,
  // selection
  output reg [24:0] monitor_select_mask_cmd,
  // pattern
  output reg diagnostic_drawing_cmd,
  output reg pattern_field,
  output reg [2:0] pattern_split,
  // wipe
  output reg wipe_go,
  output reg [2:0] wipe_dir,
  output reg [1:0] wipe_target,
  output reg [7:0] wipe_speed,
  output reg wipe_instant,
  // second source
  output reg second_source_sync,
  output reg second_source_field_skip_cmd,
  output reg [1:0] second_source_quadrant_cmd,
  output reg second_source_show_cmd,
  output reg second_source_scale_cmd,
  output reg second_source_hold_cmd,
  // zoom
  output reg zoom_go,
  output reg [15:0] zoom_x,
  output reg [15:0] zoom_y,
  output reg [7:0] zoom_percent,
  // decode result
  output reg cmd_reject,
  output reg cmd_done
);
  localparam ST_CODE = 2'h0;
  localparam ST_ARGS = 2'h1;
  localparam ST_SKIP = 2'h2;

  reg [1:0] state;
  reg [7:0] code;
  reg [4:0] idx;
  reg [7:0] arg0;
  reg [7:0] arg1;
  reg [7:0] arg2;
  reg [24:0] mask_acc;
  reg mask_bad;
  wire capture;
  wire offset_last;
  wire [7:0] offset_slot;
  integer s;

  ////////////////////////////////////////////////////////////////////////
  // parameter byte count per function code, zero for unknown codes
  function [4:0] arg_count;
    input [7:0] c;
    begin
      case (c)
        `FN_STROBE, `FN_SCAN, `FN_SKIP, `FN_QUAD: arg_count = 5'h01;
        `FN_SHOW, `FN_SCALE, `FN_HOLD: arg_count = 5'h01;
        `FN_OFFSET, `FN_PATTERN: arg_count = 5'h02;
        `FN_WIPE: arg_count = 5'h03;
        `FN_ZOOM: arg_count = 5'h04;
        `FN_SELECT: arg_count = 5'h19;
        default: arg_count = 5'h00;
      endcase
    end
  endfunction

  // binary flag check used by several codes
  function is_flag;
    input [7:0] v;
    begin
      is_flag = (v == 8'h00) || (v == 8'h01);
    end
  endfunction

  // one-hot offset slot, bit s for split s+1; zero when out of range
  function [7:0] split_onehot;
    input [7:0] v;
    begin
      case (v)
        8'h01: split_onehot = 8'h01;
        8'h02: split_onehot = 8'h02;
        8'h03: split_onehot = 8'h04;
        8'h04: split_onehot = 8'h08;
        8'h05: split_onehot = 8'h10;
        8'h06: split_onehot = 8'h20;
        8'h07: split_onehot = 8'h40;
        8'h08: split_onehot = 8'h80;
        default: split_onehot = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strobe field counter
  strobe_timer u_strobe (
    .clk(clk),
    .sys_rst(sys_rst),
    .field_start(field_start),
    .speed(strobe_speed),
    .capture(capture)
  );

  // progressive mode holds freeze between captures, so one field is stored each time;
  // interlaced mode drops it at every field start with field_odd high; strobing never blocks another effect
  always @(posedge clk) begin
    if (sys_rst) begin
      strobe_capture <= 1'b0;
      strobe_freeze <= 1'b0;
    end else begin
      strobe_capture <= capture;
      if (strobe_speed == 8'h00) begin
        strobe_freeze <= 1'b0;
      end else if (capture) begin
        strobe_freeze <= 1'b0;
      end else if (field_start) begin
        // in interlaced mode wait for the odd field to keep the full frame
        strobe_freeze <= progressive_scan_cmd | ~field_odd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor flags shift in one byte at a time, so the first flag ends in
  // bit 0; one bad flag spoils the frame, as a half-applied mask would
  // leave the wall split between two selections
  always @(posedge clk) begin
    if (sys_rst) begin
      mask_acc <= 25'h0000000;
      mask_bad <= 1'b0;
    end else if (byte_valid && (state == ST_CODE)) begin
      mask_bad <= 1'b0;
    end else if (byte_valid && (state == ST_ARGS) &&
                 (code == `FN_SELECT)) begin
      mask_acc <= {byte_data[0], mask_acc[24:1]};
      if (!is_flag(byte_data)) begin
        mask_bad <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // offset table, one signed byte per split factor, slot s-1 for split s;
  // only the addressed slot moves, so the tuning of other splits is kept;
  // an out-of-range split selects no slot at all
  assign offset_last = byte_valid && (state == ST_ARGS) &&
    (code == `FN_OFFSET) && (idx == 5'h01);
  assign offset_slot = split_onehot(arg0);
  always @(posedge clk) begin
    if (sys_rst) begin
      field_line_offset_cmd <= 64'h0000000000000000;
    end else if (offset_last) begin
      for (s = 0; s < `NUM_SPLIT; s = s + 1) begin
        if (offset_slot[s]) begin
          field_line_offset_cmd[8 * s +: 8] <= byte_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame parser and state update; a new frame_start aborts a frame
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_CODE;
      code <= 8'h00;
      idx <= 5'h00;
      arg0 <= 8'h00;
      arg1 <= 8'h00;
      arg2 <= 8'h00;
      strobe_speed <= 8'h00;
      progressive_scan_cmd <= 1'b0;
      monitor_select_mask_cmd <= `MASK_ALL;
      diagnostic_drawing_cmd <= 1'b0;
      pattern_field <= 1'b0;
      pattern_split <= 3'h0;
      wipe_go <= 1'b0;
      wipe_dir <= 3'h0;
      wipe_target <= 2'h0;
      wipe_speed <= 8'h00;
      wipe_instant <= 1'b0;
      second_source_sync <= 1'b1;
      second_source_field_skip_cmd <= 1'b0;
      second_source_quadrant_cmd <= 2'h0;
      second_source_show_cmd <= 1'b0;
      second_source_scale_cmd <= 1'b0;
      second_source_hold_cmd <= 1'b0;
      zoom_go <= 1'b0;
      zoom_x <= 16'h0000;
      zoom_y <= 16'h0000;
      zoom_percent <= `ZOOM_HALF;
      cmd_reject <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      diagnostic_drawing_cmd <= 1'b0;
      wipe_go <= 1'b0;
      zoom_go <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_done <= 1'b0;
      // second input always locked to main timing
      second_source_sync <= 1'b1;
      zoom_percent <= `ZOOM_HALF;
      if (byte_valid) begin
        case (state)
          ST_CODE: begin
            code <= byte_data;
            idx <= 5'h00;
            if (arg_count(byte_data) == 5'h00) begin
              cmd_reject <= 1'b1;
              state <= ST_SKIP;
            end else begin
              state <= ST_ARGS;
            end
          end
          ST_ARGS: begin
            idx <= idx + 5'h01;
            if (idx == 5'h00) arg0 <= byte_data;
            if (idx == 5'h01) arg1 <= byte_data;
            if (idx == 5'h02) arg2 <= byte_data;
            if (idx + 5'h01 == arg_count(code)) begin
              state <= ST_CODE;
              cmd_done <= 1'b1;
              cmd_reject <= 1'b0;
              case (code)
                `FN_STROBE: strobe_speed <= byte_data;
                `FN_SCAN: begin
                  if (is_flag(byte_data))
                    progressive_scan_cmd <= byte_data[0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_SELECT: begin
                  if (is_flag(byte_data) && !mask_bad)
                    monitor_select_mask_cmd <=
                      {byte_data[0], mask_acc[24:1]};
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_OFFSET: begin
                  // the table itself is written by the offset process
                  if (split_onehot(arg0) == 8'h00)
                    cmd_reject <= 1'b1;
                end
                `FN_PATTERN: begin
                  // the drawing engine renders diagonals, circle, number
                  if (is_flag(arg0) && byte_data <= 8'h05) begin
                    diagnostic_drawing_cmd <= 1'b1;
                    pattern_field <= arg0[0];
                    pattern_split <= byte_data[2:0];
                  end else begin
                    cmd_reject <= 1'b1;
                  end
                end
                `FN_WIPE: begin
                  if (arg0 <= 8'h05 && arg1 <= 8'h02) begin
                    wipe_go <= 1'b1;
                    wipe_dir <= arg0[2:0];
                    wipe_target <= arg1[1:0];
                    wipe_speed <= byte_data;
                    wipe_instant <= (byte_data == 8'h00);
                  end else begin
                    cmd_reject <= 1'b1;
                  end
                end
                `FN_SKIP: begin
                  if (is_flag(byte_data))
                    second_source_field_skip_cmd <= byte_data[0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_QUAD: begin
                  if (byte_data <= 8'h03)
                    second_source_quadrant_cmd <= byte_data[1:0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_SHOW: begin
                  if (is_flag(byte_data))
                    second_source_show_cmd <= byte_data[0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_SCALE: begin
                  // quarter size: pipeline drops every other pixel and line
                  if (is_flag(byte_data))
                    second_source_scale_cmd <= byte_data[0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_HOLD: begin
                  // separate from the strobe freeze of the main store
                  if (is_flag(byte_data))
                    second_source_hold_cmd <= byte_data[0];
                  else
                    cmd_reject <= 1'b1;
                end
                `FN_ZOOM: begin
                  // x = arg1:arg0, y = byte_data:arg2, low byte first
                  if ({arg1, arg0} <= `ZOOM_X_MAX &&
                      {byte_data, arg2} <= `ZOOM_Y_MAX) begin
                    zoom_go <= 1'b1;
                    zoom_x <= {arg1, arg0};
                    zoom_y <= {byte_data, arg2};
                  end else begin
                    cmd_reject <= 1'b1;
                  end
                end
                default: begin
                  cmd_reject <= 1'b1;
                  cmd_done <= 1'b0;
                end
              endcase
            end
          end
          ST_SKIP: state <= ST_SKIP;
          default: state <= ST_CODE;
        endcase
      end
      // a frame boundary always resynchronises the parser
      if (frame_start) begin
        state <= ST_CODE;
        idx <= 5'h00;
      end
    end
  end
  // per-monitor commands are not decoded here, so the mask never gates
  // them; downstream must apply the mask to global commands only
endmodule // fx_command_decoder

/* verif/fx_command_decoder_props.sv */
// concurrent checks on the effects command decoder ports
`timescale 1ns/100ps
`include "fx_decoder_defines.vh"
module fx_decoder_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // strobe
  input wire field_start,
  input wire [7:0] strobe_speed,
  input wire strobe_capture,
  // state and results
  input wire [24:0] monitor_select_mask_cmd,
  input wire wipe_go,
  input wire [2:0] wipe_dir,
  input wire [1:0] wipe_target,
  input wire [7:0] wipe_speed,
  input wire wipe_instant,
  input wire second_source_sync,
  input wire [7:0] zoom_percent,
  input wire cmd_reject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  a_sync_held: assert property (second_source_sync)
    else $error("second source sync dropped");
  a_zoom_half: assert property (zoom_percent == `ZOOM_HALF)
    else $error("zoom factor not fifty percent");
  a_mask_reset: assert property (
    $fell(sys_rst) |-> monitor_select_mask_cmd == `MASK_ALL)
    else $error("mask not all selected after reset");
  // speed must have been zero long enough that no capture was in flight
  a_strobe_off: assert property (
    strobe_speed == 8'h00 && $past(strobe_speed) == 8'h00 &&
    $past(strobe_speed, 2) == 8'h00 |-> !strobe_capture)
    else $error("capture while strobe off");
  a_capture_cause: assert property (
    strobe_capture |-> $past(field_start, 2))
    else $error("capture not tied to a field start");
  a_wipe_instant: assert property (
    wipe_go |-> wipe_instant == (wipe_speed == 8'h00))
    else $error("instant flag disagrees with speed");
  a_wipe_range: assert property (
    wipe_go |-> wipe_dir <= 3'h5 && wipe_target <= 2'h2)
    else $error("wipe issued with illegal code");
  a_reject_keeps: assert property (
    cmd_reject |-> $stable(monitor_select_mask_cmd) && $stable(strobe_speed))
    else $error("state changed on rejected command");
endmodule // fx_decoder_props
bind fx_command_decoder fx_decoder_props u_props (
  .clk(clk), .sys_rst(sys_rst), .field_start(field_start),
  .strobe_speed(strobe_speed), .strobe_capture(strobe_capture),
  .monitor_select_mask_cmd(monitor_select_mask_cmd), .wipe_go(wipe_go),
  .wipe_dir(wipe_dir), .wipe_target(wipe_target), .wipe_speed(wipe_speed),
  .wipe_instant(wipe_instant), .second_source_sync(second_source_sync),
  .zoom_percent(zoom_percent), .cmd_reject(cmd_reject)
);

/* verif/host_link_model.sv */
// host controller model sending framed command bytes
`timescale 1ns/100ps
module host_link_model (
  // clock
  input wire clk,
  // command link
  output reg byte_valid,
  output reg [7:0] byte_data,
  output reg frame_start
);
  reg [7:0] msg [0:25];
  // idle link carries no strobe
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    frame_start = 1'b0;
  end
  // marker a cycle ahead of the code, since a byte with it is dropped
  task send(input integer n, input integer gap);
    integer i, j;
    begin
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        for (j = 0; j < gap; j = j + 1) begin
          byte_valid <= 1'b0;
          byte_data <= ~byte_data; // stale byte never lingers on the line
          @(posedge clk);
        end
        byte_valid <= 1'b1;
        byte_data <= msg[i];
        @(posedge clk);
      end
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  endtask
endmodule // host_link_model

/* verif/tb_fx_command_decoder.sv */
// self-checking bench for the effects command decoder
`timescale 1ns/100ps
`include "fx_decoder_defines.vh"
module tb_fx_command_decoder;
  reg clk, sys_rst, field_start, field_odd;
  integer miscompares, n_checks, cyc, fields, caps, gap, i, frz;
  reg [24:0] em;
  reg [4:0] ef;
  reg [1:0] et;
  wire strobe_freeze;
  wire byte_valid, frame_start, strobe_capture, progressive_scan_cmd;
  wire [7:0] byte_data, strobe_speed, wipe_speed, zoom_percent;
  wire [63:0] field_line_offset_cmd;
  wire [24:0] monitor_select_mask_cmd;
  wire diagnostic_drawing_cmd, pattern_field, wipe_go, wipe_instant;
  wire [2:0] pattern_split, wipe_dir;
  wire [1:0] wipe_target, second_source_quadrant_cmd;
  wire second_source_sync, second_source_field_skip_cmd;
  wire second_source_show_cmd, second_source_scale_cmd;
  wire second_source_hold_cmd, zoom_go, cmd_reject, cmd_done;
  wire [15:0] zoom_x, zoom_y;
  wire [4:0] flags = {progressive_scan_cmd, second_source_field_skip_cmd,
    second_source_show_cmd, second_source_scale_cmd, second_source_hold_cmd};
  fx_command_decoder dut (.clk(clk), .sys_rst(sys_rst),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .frame_start(frame_start), .field_start(field_start),
    .field_odd(field_odd), .strobe_speed(strobe_speed),
    .strobe_freeze(strobe_freeze),
    .strobe_capture(strobe_capture),
    .progressive_scan_cmd(progressive_scan_cmd),
    .field_line_offset_cmd(field_line_offset_cmd),
    .monitor_select_mask_cmd(monitor_select_mask_cmd),
    .diagnostic_drawing_cmd(diagnostic_drawing_cmd),
    .pattern_field(pattern_field), .pattern_split(pattern_split),
    .wipe_go(wipe_go), .wipe_dir(wipe_dir), .wipe_target(wipe_target),
    .wipe_speed(wipe_speed), .wipe_instant(wipe_instant),
    .second_source_sync(second_source_sync),
    .second_source_field_skip_cmd(second_source_field_skip_cmd),
    .second_source_quadrant_cmd(second_source_quadrant_cmd),
    .second_source_show_cmd(second_source_show_cmd),
    .second_source_scale_cmd(second_source_scale_cmd),
    .second_source_hold_cmd(second_source_hold_cmd), .zoom_go(zoom_go),
    .zoom_x(zoom_x), .zoom_y(zoom_y), .zoom_percent(zoom_percent),
    .cmd_reject(cmd_reject), .cmd_done(cmd_done));
  host_link_model host (.clk(clk), .byte_valid(byte_valid),
    .byte_data(byte_data), .frame_start(frame_start));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [8*10:1] nm, input [63:0] exp, input [63:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %0h got %0h", nm, exp, got);
      end
    end
  endtask
  task load(input [7:0] a, b, c, d, e);
    begin
      host.msg[0] = a;
      host.msg[1] = b;
      host.msg[2] = c;
      host.msg[3] = d;
      host.msg[4] = e;
    end
  endtask
  // send one frame and look at the one-cycle response pulses
  task cmd(input integer n, input rej);
    begin
      @(posedge clk);
      host.send(n, gap);
      #1;
      chk("reject", rej, cmd_reject);
      if (!rej) chk("done", 1'b1, cmd_done);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // free-running fields every 20 cycles; also the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    field_start <= (cyc % 20 == 19);
    if (field_start === 1'b1) field_odd <= ~field_odd;
    if (field_start === 1'b1) fields <= fields + 1;
    if (strobe_capture === 1'b1) caps <= caps + 1;
    if (strobe_freeze === 1'b1) frz <= frz + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  initial begin
    {sys_rst, field_start, field_odd} = 3'b100;
    {miscompares, n_checks, cyc, fields, caps, gap, frz} = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("mask", `MASK_ALL, monitor_select_mask_cmd);
    chk("sync", 1'b1, second_source_sync);
    chk("zoom_pct", `ZOOM_HALF, zoom_percent);
    $display("test reset done");
    ef = 5'h00;
    for (i = 0; i < 5; i = i + 1) begin
      load({`FN_SCAN, `FN_SKIP, `FN_SHOW, `FN_SCALE, `FN_HOLD} >> (32 - 8 * i),
        1, 0, 0, 0);
      cmd(2, 0);
      ef = ef | (5'h10 >> i);
      chk("flags", ef, flags);
      host.msg[1] = 8'h02;
      cmd(2, 1);
      chk("flags", ef, flags);
    end
    $display("test flags done");
    for (i = 0; i < 5; i = i + 1) begin
      load(`FN_QUAD, i, 0, 0, 0);
      cmd(2, i == 4);
      chk("quadrant", (i == 4) ? 3 : i, second_source_quadrant_cmd);
    end
    load(`FN_OFFSET, 3, 8'hFE, 0, 0);
    cmd(3, 0);
    chk("offset", 8'hFE, field_line_offset_cmd[23:16]);
    load(`FN_OFFSET, 8, 8'h05, 0, 0);
    cmd(3, 0);
    chk("offset", 64'h0500000000FE0000, field_line_offset_cmd);
    load(`FN_OFFSET, 0, 1, 0, 0);
    cmd(3, 1);
    $display("test quadrant offset done");
    gap = 1;
    host.msg[0] = `FN_SELECT;
    for (i = 0; i < 25; i = i + 1) begin
      host.msg[i + 1] = (i % 3 == 0);
      em[i] = (i % 3 == 0);
    end
    cmd(26, 0);
    chk("mask", em, monitor_select_mask_cmd);
    host.msg[13] = 8'h02;
    cmd(26, 1);
    chk("mask", em, monitor_select_mask_cmd);
    gap = 0;
    $display("test mask done");
    for (i = 0; i < 6; i = i + 1) begin
      load(`FN_WIPE, i, i % 3, i * 40, 0);
      cmd(4, 0);
      et = i % 3;
      chk("wipe", {1'b1, i[2:0], et, i == 0},
        {wipe_go, wipe_dir, wipe_target, wipe_instant});
      chk("wipe_speed", i * 40, wipe_speed);
    end
    load(`FN_WIPE, 6, 0, 9, 0);
    cmd(4, 1);
    load(`FN_WIPE, 1, 3, 9, 0);
    cmd(4, 1);
    $display("test wipe done");
    load(`FN_PATTERN, 1, 5, 0, 0);
    cmd(3, 0);
    chk("pattern", 5'h1D,
      {diagnostic_drawing_cmd, pattern_field, pattern_split});
    load(`FN_PATTERN, 0, 6, 0, 0);
    cmd(3, 1);
    load(`FN_ZOOM, 8'h7B, 8'h01, 8'h2B, 8'h01);
    cmd(5, 0);
    chk("zoom", 33'h1017B012B, {zoom_go, zoom_x, zoom_y});
    host.msg[1] = 8'h7C;
    cmd(5, 1);
    load(8'h01, 0, 0, 0, 0);
    cmd(1, 1);
    $display("test pattern zoom done");
    gap = 2;
    load(`FN_STROBE, 3, 0, 0, 0);
    cmd(2, 0);
    chk("speed", 8'h03, strobe_speed);
    fields = 0;
    caps = 0;
    frz = 0;
    for (i = 0; i < 400 && fields < 12; i = i + 1)
      @(posedge clk);
    repeat (3) @(posedge clk);
    chk("captures", 4, caps);
    chk("freeze", 1, frz > 0);
    load(`FN_STROBE, 0, 0, 0, 0);
    cmd(2, 0);
    {fields, caps, frz} = 0;
    for (i = 0; i < 200 && fields < 6; i = i + 1)
      @(posedge clk);
    chk("captures", 0, caps);
    chk("freeze", 0, strobe_freeze);
    $display("test strobe done");
    conclude;
  end
endmodule // tb_fx_command_decoder
